/* File: mspc_pkg.sv */
// Package for the motion sample path configuration block.
// Assumes an 8-bit register port and a single 100 MHz clock.
package mspc_pkg;
    localparam logic [7:0] ADDR_DIVIDER = 8'h19;
    localparam logic [7:0] ADDR_SYNC_FILTER = 8'h1a;
    localparam logic [7:0] ADDR_RATE_SENSOR = 8'h1b;
    localparam logic [7:0] ADDR_STATUS = 8'h1f;
    localparam logic [7:0] RST_DIVIDER = 8'h00;
    localparam logic [7:0] RST_SYNC_FILTER = 8'h00;
    localparam logic [7:0] RST_RATE_SENSOR = 8'h00;
    localparam int STOP_FULL_BIT = 6;
    localparam int SLOT_LSB = 3;
    localparam int LPF_LSB = 0;
    localparam int RANGE_LSB = 3;
    localparam int BYPASS_LSB = 0;
    localparam logic [7:0] SYNC_FILTER_WMASK = 8'h7f;
    localparam logic [7:0] RATE_SENSOR_WMASK = 8'hfb;
    localparam int CLK_HZ = 100_000_000;
    localparam int RATE_32K_HZ = 32_000;
    localparam int RATE_8K_HZ = 8_000;
    localparam int RATE_1K_HZ = 1_000;
    localparam int DIV_32K = CLK_HZ / RATE_32K_HZ;
    localparam int DIV_8K = CLK_HZ / RATE_8K_HZ;
    localparam int DIV_1K = CLK_HZ / RATE_1K_HZ;
    localparam logic [2:0] SLOT_OFF = 3'h0;
    localparam logic [2:0] SLOT_TEMP = 3'h1;
    localparam logic [2:0] SLOT_RATE_X = 3'h2;
    localparam logic [2:0] SLOT_RATE_Y = 3'h3;
    localparam logic [2:0] SLOT_RATE_Z = 3'h4;
    localparam logic [2:0] SLOT_ACC_X = 3'h5;
    localparam logic [2:0] SLOT_ACC_Y = 3'h6;
    localparam logic [2:0] SLOT_ACC_Z = 3'h7;
    localparam logic [3:0] BW_8173 = 4'h0;
    localparam logic [3:0] BW_3281 = 4'h1;
    localparam logic [3:0] BW_250 = 4'h2;
    localparam logic [3:0] BW_176 = 4'h3;
    localparam logic [3:0] BW_92 = 4'h4;
    localparam logic [3:0] BW_41 = 4'h5;
    localparam logic [3:0] BW_20 = 4'h6;
    localparam logic [3:0] BW_10 = 4'h7;
    localparam logic [3:0] BW_5 = 4'h8;
    localparam logic [1:0] RATE_SEL_32K = 2'h0;
    localparam logic [1:0] RATE_SEL_8K = 2'h1;
    localparam logic [1:0] RATE_SEL_1K = 2'h2;
    typedef enum logic [1:0] {
        MSPC_RANGE_250 = 2'b00,
        MSPC_RANGE_500 = 2'b01,
        MSPC_RANGE_1000 = 2'b10,
        MSPC_RANGE_2000 = 2'b11
    } mspc_range_t;
    typedef enum logic [1:0] {
        MSPC_SYNC_IDLE = 2'b00,
        MSPC_SYNC_HELD = 2'b01
    } mspc_sync_t;
endpackage

/* File: mspc_fifo_if.sv */
// Interface between the sample path and its sample memory.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
interface mspc_fifo_if #(parameter int WIDTH = 16, parameter int AW = 4);
    logic wr_en;
    logic [WIDTH-1:0] wr_data;
    logic rd_en;
    logic [WIDTH-1:0] rd_data;
    logic full;
    logic empty;
    logic [AW:0] level;
    modport owner (output wr_en, output wr_data, output rd_en,
        input rd_data, input full, input empty, input level);
    modport mem (input wr_en, input wr_data, input rd_en,
        output rd_data, output full, output empty, output level);
endinterface

/* File: mspc_fifo.sv */
// Sample memory with stop-on-full or overwrite-oldest policy.
// Assumes one clock; read data registered, valid the cycle after rd_en.
`timescale 1ns/10ps
module mspc_fifo #(
    parameter int WIDTH = 16,
    parameter int AW = 4
) (
    input wire logic core_clk_in, // Clock
    input wire logic nrst_in, // Async reset, low
    input wire logic clk_en_in, // Freezes state when low
    input wire logic stop_full_in, // 1 discards writes when full
    mspc_fifo_if.mem port // Memory side
);
    localparam int DEPTH = 1 << AW;
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
    logic [AW:0] count, next_count;
    logic [WIDTH-1:0] rdata, next_rdata;
    logic do_wr, do_rd, drop_old;

    always_comb begin
        do_rd = port.rd_en && (count != '0);
        drop_old = port.wr_en && !stop_full_in && (count == (AW+1)'(DEPTH)) && !do_rd;
        do_wr = port.wr_en && (count != (AW+1)'(DEPTH) || !stop_full_in || do_rd);
        next_wptr = do_wr ? wptr + 1'b1 : wptr;
        next_rptr = (do_rd || drop_old) ? rptr + 1'b1 : rptr;
        next_count = count;
        if (do_wr && !do_rd && !drop_old) begin
            next_count = count + 1'b1;
        end else if (do_rd && !do_wr) begin
            next_count = count - 1'b1;
        end
        next_rdata = do_rd ? store[rptr] : rdata;
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
            rdata <= '0;
        end else if (clk_en_in) begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            count <= next_count;
            rdata <= next_rdata;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (clk_en_in && do_wr) begin
            store[wptr] <= port.wr_data;
        end
    end

    assign port.rd_data = rdata;
    assign port.full = (count == (AW+1)'(DEPTH));
    assign port.empty = (count == '0);
    assign port.level = count;

    chk_stop_full_hold: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        clk_en_in && stop_full_in && port.full && port.wr_en && !port.rd_en
        |=> port.full && $stable(wptr))
        else $error("write taken while full in stop mode");
    chk_overwrite_full: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        clk_en_in && !stop_full_in && port.full && port.wr_en && !port.rd_en
        |=> port.full && rptr == $past(rptr) + 1'b1)
        else $error("oldest entry not replaced");
endmodule // mspc_fifo

/* File: mspc_top.sv */
// Sampling path configuration: sync insertion, filter/rate select, range.
// Assumes sample words arrive synchronous to the clock, one per strobe.
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////
module mspc_top #(
    parameter int AW = 4
) (
    input wire logic core_clk_in, // Clock, 100 MHz
    input wire logic nrst_in, // Async reset, active low
    input wire logic clk_en_in, // Freezes all state when low
    input wire logic [7:0] addr_in, // Register address
    input wire logic [7:0] wdata_in, // Register write data
    input wire logic wr_in, // Write strobe
    input wire logic rd_in, // Read strobe
    input wire logic frame_sync_input, // Frame-sync pin level
    input wire logic [7:0] slot_lsb_in, // Low bytes: temp,gx,gy,gz,ax,ay,az (bit per slot)
    input wire logic [15:0] sample_in, // Sample word to enqueue
    input wire logic fifo_pop_in, // Read one sample from the FIFO
    output logic [7:0] rdata_out, // Register read data
    output logic sample_strobe_out, // Internal sample-rate strobe
    output logic output_strobe_out, // Divided output-rate strobe
    output logic [7:0] slot_lsb_out, // Low-byte bit 0 per slot after insertion
    output logic [3:0] bandwidth_code_out, // Active gyro bandwidth code
    output logic [1:0] rate_code_out, // Active internal rate code
    output logic [1:0] gyro_range_select, // Full-scale code
    output logic [15:0] fifo_data_out, // FIFO read data
    output logic fifo_full_out // FIFO full
);
    logic [7:0] divider, sync_filter, rate_sensor;
    logic [7:0] next_divider, next_sync_filter, next_rate_sensor, next_rdata;
    // Wide enough for the slowest rate, a 100000-cycle period
    logic [16:0] tick_cnt, next_tick_cnt;
    logic [7:0] div_cnt, next_div_cnt;
    logic sync_latched, next_sync_latched, sync_prev, next_sync_prev;
    mspc_pkg::mspc_sync_t sync_state, next_sync_state;
    logic next_sample_strobe, next_output_strobe;
    logic [7:0] next_slot_lsb;
    logic [3:0] next_bw;
    logic [1:0] next_rate;
    logic [2:0] sync_slot_select, lowpass_select;
    logic [1:0] filter_bypass;
    logic [16:0] period;
    logic divided;

    mspc_fifo_if #(.WIDTH(16), .AW(AW)) fifo_bus ();

    function automatic logic [3:0] bw_of(input logic [1:0] byp, input logic [2:0] sel);
        logic [3:0] r;
        r = mspc_pkg::BW_250;
        if (byp[0]) begin
            r = mspc_pkg::BW_8173;
        end else if (byp[1]) begin
            r = mspc_pkg::BW_3281;
        end else begin
            case (sel)
                3'h0: r = mspc_pkg::BW_250;
                3'h1: r = mspc_pkg::BW_176;
                3'h2: r = mspc_pkg::BW_92;
                3'h3: r = mspc_pkg::BW_41;
                3'h4: r = mspc_pkg::BW_20;
                3'h5: r = mspc_pkg::BW_10;
                3'h6: r = mspc_pkg::BW_5;
                default: r = mspc_pkg::BW_3281;
            endcase
        end
        return r;
    endfunction

    function automatic logic [1:0] rate_of(input logic [1:0] byp, input logic [2:0] sel);
        if (byp != 2'b00) begin
            return mspc_pkg::RATE_SEL_32K;
        end else if (sel == 3'h0 || sel == 3'h7) begin
            return mspc_pkg::RATE_SEL_8K;
        end
        return mspc_pkg::RATE_SEL_1K;
    endfunction

    always_comb begin
        sync_slot_select = sync_filter[mspc_pkg::SLOT_LSB +: 3];
        lowpass_select = sync_filter[mspc_pkg::LPF_LSB +: 3];
        filter_bypass = rate_sensor[mspc_pkg::BYPASS_LSB +: 2];
    end

    //////////////////////////////////////////////////////////////////////
    // Register port
    always_comb begin
        next_divider = divider;
        next_sync_filter = sync_filter;
        next_rate_sensor = rate_sensor;
        next_rdata = 8'h00;
        if (wr_in) begin
            case (addr_in)
                mspc_pkg::ADDR_DIVIDER: next_divider = wdata_in;
                // Reserved bits are forced low in case software misbehaves
                mspc_pkg::ADDR_SYNC_FILTER: begin
                    next_sync_filter = wdata_in & mspc_pkg::SYNC_FILTER_WMASK;
                end
                mspc_pkg::ADDR_RATE_SENSOR: begin
                    next_rate_sensor = wdata_in & mspc_pkg::RATE_SENSOR_WMASK;
                end
                default: next_divider = divider;
            endcase
        end
        if (rd_in) begin
            case (addr_in)
                mspc_pkg::ADDR_DIVIDER: next_rdata = divider;
                mspc_pkg::ADDR_SYNC_FILTER: next_rdata = sync_filter;
                mspc_pkg::ADDR_RATE_SENSOR: next_rdata = rate_sensor;
                mspc_pkg::ADDR_STATUS: next_rdata = {fifo_bus.full, fifo_bus.empty,
                    sync_latched, 1'b0, bw_of(filter_bypass, lowpass_select)};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            divider <= mspc_pkg::RST_DIVIDER;
            sync_filter <= mspc_pkg::RST_SYNC_FILTER;
            rate_sensor <= mspc_pkg::RST_RATE_SENSOR;
            rdata_out <= 8'h00;
        end else if (clk_en_in) begin
            divider <= next_divider;
            sync_filter <= next_sync_filter;
            rate_sensor <= next_rate_sensor;
            rdata_out <= next_rdata;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Rate generation
    always_comb begin
        case (rate_of(filter_bypass, lowpass_select))
            mspc_pkg::RATE_SEL_32K: period = 17'(mspc_pkg::DIV_32K);
            mspc_pkg::RATE_SEL_8K: period = 17'(mspc_pkg::DIV_8K);
            default: period = 17'(mspc_pkg::DIV_1K);
        endcase
        next_sample_strobe = (tick_cnt >= period - 17'h0_0001);
        next_tick_cnt = next_sample_strobe ? 17'h0_0000 : tick_cnt + 17'h0_0001;
        divided = (filter_bypass == 2'b00) && (lowpass_select != 3'h0)
            && (lowpass_select != 3'h7);
        next_div_cnt = div_cnt;
        next_output_strobe = 1'b0;
        if (next_sample_strobe) begin
            if (!divided || div_cnt >= divider) begin
                next_div_cnt = 8'h00;
                next_output_strobe = 1'b1;
            end else begin
                next_div_cnt = div_cnt + 8'h01;
            end
        end
        next_bw = bw_of(filter_bypass, lowpass_select);
        next_rate = rate_of(filter_bypass, lowpass_select);
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tick_cnt <= 17'h0_0000;
            div_cnt <= 8'h00;
            sample_strobe_out <= 1'b0;
            output_strobe_out <= 1'b0;
            bandwidth_code_out <= mspc_pkg::BW_250;
            rate_code_out <= mspc_pkg::RATE_SEL_8K;
            gyro_range_select <= mspc_pkg::MSPC_RANGE_250;
        end else if (clk_en_in) begin
            tick_cnt <= next_tick_cnt;
            div_cnt <= next_div_cnt;
            sample_strobe_out <= next_sample_strobe;
            output_strobe_out <= next_output_strobe;
            bandwidth_code_out <= next_bw;
            rate_code_out <= next_rate;
            gyro_range_select <= rate_sensor[mspc_pkg::RANGE_LSB +: 2];
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Frame-sync latch and insertion
    always_comb begin
        next_sync_prev = frame_sync_input;
        next_sync_latched = sync_latched;
        next_sync_state = sync_state;
        next_slot_lsb = slot_lsb_in;
        case (sync_state)
            mspc_pkg::MSPC_SYNC_IDLE: begin
                if (frame_sync_input != sync_prev) begin
                    next_sync_latched = !sync_latched;
                    next_sync_state = mspc_pkg::MSPC_SYNC_HELD;
                end
            end
            mspc_pkg::MSPC_SYNC_HELD: begin
                // No further flip until captured; short pulses are not lost
                if (next_sample_strobe) begin
                    next_sync_state = mspc_pkg::MSPC_SYNC_IDLE;
                end
            end
            default: next_sync_state = mspc_pkg::MSPC_SYNC_IDLE;
        endcase
        if (next_sample_strobe && sync_slot_select != mspc_pkg::SLOT_OFF) begin
            // Slot 5 is accel X, between gyro Z and accel Y
            next_slot_lsb[3'(sync_slot_select - 3'h1)] = sync_latched;
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync_prev <= 1'b0;
            sync_latched <= 1'b0;
            sync_state <= mspc_pkg::MSPC_SYNC_IDLE;
            slot_lsb_out <= 8'h00;
        end else if (clk_en_in) begin
            sync_prev <= next_sync_prev;
            sync_latched <= next_sync_latched;
            sync_state <= next_sync_state;
            slot_lsb_out <= next_slot_lsb;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Sample FIFO
    assign fifo_bus.wr_en = sample_strobe_out;
    assign fifo_bus.wr_data = sample_in;
    assign fifo_bus.rd_en = fifo_pop_in;

    mspc_fifo #(.WIDTH(16), .AW(AW)) u_fifo (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .clk_en_in(clk_en_in),
        .stop_full_in(sync_filter[mspc_pkg::STOP_FULL_BIT]),
        .port(fifo_bus.mem)
    );

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fifo_data_out <= 16'h0000;
            fifo_full_out <= 1'b0;
        end else if (clk_en_in) begin
            fifo_data_out <= fifo_bus.rd_data;
            fifo_full_out <= fifo_bus.full;
        end
    end

    //////////////////////////////////////////////////////////////////////
    sequence s_flip;
        clk_en_in && sync_state == mspc_pkg::MSPC_SYNC_IDLE && frame_sync_input != sync_prev;
    endsequence
    sequence s_capture;
        clk_en_in && next_sample_strobe;
    endsequence
    chk_sync_flip: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        s_flip |=> sync_latched != $past(sync_latched))
        else $error("sync toggle not latched");
    chk_sync_hold: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        sync_state == mspc_pkg::MSPC_SYNC_HELD |=> $stable(sync_latched))
        else $error("latched sync flipped twice");
    chk_held_rearm: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        s_capture ##0 sync_state == mspc_pkg::MSPC_SYNC_HELD
        |=> sync_state == mspc_pkg::MSPC_SYNC_IDLE)
        else $error("sync latch not re-armed by strobe");
    chk_bypass_rate: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        clk_en_in && filter_bypass != 2'b00 |=> rate_code_out == mspc_pkg::RATE_SEL_32K)
        else $error("bypass rate wrong");
    chk_bypass_wide: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        clk_en_in && filter_bypass[0] |=> bandwidth_code_out == mspc_pkg::BW_8173)
        else $error("wide bypass bandwidth wrong");
    chk_lpf_rate: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        clk_en_in && filter_bypass == 2'b00 && lowpass_select == 3'h3
        |=> rate_code_out == mspc_pkg::RATE_SEL_1K
        && bandwidth_code_out == mspc_pkg::BW_41)
        else $error("filter select wrong");
    chk_lpf_fast: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        clk_en_in && filter_bypass == 2'b00
        && (lowpass_select == 3'h0 || lowpass_select == 3'h7)
        |=> rate_code_out == mspc_pkg::RATE_SEL_8K)
        else $error("fast filter rate wrong");
    chk_bypass_bw: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        clk_en_in && filter_bypass == 2'b10 |=> bandwidth_code_out == mspc_pkg::BW_3281)
        else $error("bypass bandwidth wrong");
    chk_range_follow: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        clk_en_in |=> gyro_range_select == $past(rate_sensor[4:3]))
        else $error("range not followed");
    chk_slot_off: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        s_capture ##0 sync_slot_select == mspc_pkg::SLOT_OFF
        |=> slot_lsb_out == $past(slot_lsb_in))
        else $error("sync inserted while disabled");
    chk_slot_insert: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        s_capture ##0 sync_slot_select == mspc_pkg::SLOT_ACC_X
        |=> slot_lsb_out[4] == $past(sync_latched))
        else $error("sync not inserted");
    chk_div_out: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        output_strobe_out |-> sample_strobe_out)
        else $error("output strobe without sample strobe");
    chk_undivided: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        s_capture ##0 !divided |=> output_strobe_out)
        else $error("undivided strobe not passed to output");
endmodule // mspc_top

/* File: mspc_host_model.sv */
// Host register master model for the sample path configuration block.
// Assumes the block answers a read in the cycle after the strobe, never stalls.
`timescale 1ns/10ps
module mspc_host_model (
    input wire logic core_clk_in, // Clock
    input wire logic [7:0] rdata_in, // Read data from block
    output logic [7:0] addr_out, // Register address
    output logic [7:0] wdata_out, // Write data
    output logic wr_out, // Write strobe
    output logic rd_out // Read strobe
);
    initial begin
        addr_out = 8'h00;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    //////////////////////////////////////////////////////////////////////////
    // Reserved bits always go out as zero, whatever the caller asks
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] m;
        m = (a == mspc_pkg::ADDR_SYNC_FILTER) ? mspc_pkg::SYNC_FILTER_WMASK : 8'hff;
        if (a == mspc_pkg::ADDR_RATE_SENSOR) begin
            m = mspc_pkg::RATE_SENSOR_WMASK;
        end
        @(posedge core_clk_in);
        addr_out <= a;
        wdata_out <= d & m;
        wr_out <= 1'b1;
        @(posedge core_clk_in);
        wr_out <= 1'b0;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge core_clk_in);
        rd_out <= 1'b0;
        // Data stands only in this cycle
        #1;
        d = rdata_in;
    endtask
endmodule // mspc_host_model

/* File: testbench.sv */
// Self-checking bench for the sample path configuration block.
// Assumes a 100 MHz clock; FIFO shrunk to depth 4 to keep the run short.
`timescale 1ns/10ps
module testbench;
    localparam int LIMIT = 95000;
    logic core_clk, nrst, fs, pop;
    logic [7:0] addr, wdata, rdata, slot_in, slot_out, rd_val;
    logic wr, rd, s_stb, o_stb, full, en;
    logic [3:0] bw;
    logic [1:0] rate, range;
    logic [15:0] sample, fdata;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    int gap = 0;
    logic lat = 1'b0;
    logic [3:0] bw_tab [8] = '{mspc_pkg::BW_250, mspc_pkg::BW_176, mspc_pkg::BW_92,
        mspc_pkg::BW_41, mspc_pkg::BW_20, mspc_pkg::BW_10, mspc_pkg::BW_5, mspc_pkg::BW_3281};
    mspc_host_model host (.core_clk_in(core_clk), .rdata_in(rdata), .addr_out(addr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
    mspc_top #(.AW(2)) dut (.core_clk_in(core_clk), .nrst_in(nrst), .clk_en_in(en),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .frame_sync_input(fs),
        .slot_lsb_in(slot_in), .sample_in(sample), .fifo_pop_in(pop), .rdata_out(rdata),
        .sample_strobe_out(s_stb), .output_strobe_out(o_stb), .slot_lsb_out(slot_out),
        .bandwidth_code_out(bw), .rate_code_out(rate), .gyro_range_select(range),
        .fifo_data_out(fdata), .fifo_full_out(full));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    //////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (fail_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            end_of_test();
        end
    end
    // Leaves the bench inside the strobe cycle, 1 ns after its edge; gap counts edges waited
    task automatic wait_strobe();
        gap = 0;
        do begin
            @(posedge core_clk);
            #1;
            gap++;
        end while (s_stb !== 1'b1 && gap < 4000);
        check("sample_strobe_out", {15'h0000, s_stb}, 16'h0001);
    endtask
    task automatic codes(input logic [1:0] r, input logic [3:0] b);
        repeat (3) @(posedge core_clk);
        #1;
        check("rate_code_out", {14'h0000, rate}, {14'h0000, r});
        check("bandwidth_code_out", {12'h000, bw}, {12'h000, b});
    endtask
    task automatic pop_one(output logic [15:0] d);
        @(posedge core_clk);
        pop <= 1'b1;
        @(posedge core_clk);
        pop <= 1'b0;
        @(posedge core_clk);
        #1;
        d = fdata;
    endtask
    // Drain, push six samples into a depth-4 FIFO, then read four back
    task automatic fifo_run(input logic stop, input int first);
        logic [15:0] d;
        host.write_reg(mspc_pkg::ADDR_SYNC_FILTER, {1'b0, stop, 6'h00});
        wait_strobe();
        repeat (6) pop_one(d);
        for (int k = 0; k < 6; k++) begin
            @(posedge core_clk);
            sample <= 16'h1000 + 16'(k);
            wait_strobe();
        end
        check("fifo_full_out", {15'h0000, full}, 16'h0001);
        for (int k = 0; k < 4; k++) begin
            pop_one(d);
            check("fifo_data_out", d, 16'h1000 + 16'(first + k));
        end
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        fs = 1'b0;
        pop = 1'b0;
        en = 1'b1;
        slot_in = 8'haa;
        sample = 16'h0000;
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        codes(mspc_pkg::RATE_SEL_8K, mspc_pkg::BW_250);
        host.read_reg(mspc_pkg::ADDR_SYNC_FILTER, rd_val);
        check("sync_filter_config", {8'h00, rd_val}, {8'h00, mspc_pkg::RST_SYNC_FILTER});
        host.read_reg(mspc_pkg::ADDR_RATE_SENSOR, rd_val);
        check("rate_sensor_config", {8'h00, rd_val}, {8'h00, mspc_pkg::RST_RATE_SENSOR});
        host.read_reg(8'h05, rd_val);
        check("unmapped read", {8'h00, rd_val}, 16'h0000);
        for (int lp = 0; lp < 8; lp++) begin
            host.write_reg(mspc_pkg::ADDR_SYNC_FILTER, 8'(lp));
            codes((lp == 0 || lp == 7) ? mspc_pkg::RATE_SEL_8K : mspc_pkg::RATE_SEL_1K,
                bw_tab[lp]);
        end
        // Filter choice must be ignored once any bypass bit is set
        host.write_reg(mspc_pkg::ADDR_SYNC_FILTER, 8'h03);
        for (int bp = 1; bp < 4; bp++) begin
            host.write_reg(mspc_pkg::ADDR_RATE_SENSOR, 8'(bp));
            codes(mspc_pkg::RATE_SEL_32K, bp[0] ? mspc_pkg::BW_8173 : mspc_pkg::BW_3281);
        end
        for (int r = 0; r < 4; r++) begin
            host.write_reg(mspc_pkg::ADDR_RATE_SENSOR, {3'b000, 2'(r), 3'b001});
            host.read_reg(mspc_pkg::ADDR_RATE_SENSOR, rd_val);
            check("rate_sensor_config", {8'h00, rd_val}, {11'h000, 2'(r), 3'b001});
            check("gyro_range_select", {14'h0000, range}, 16'(r));
        end
        // A write while the clock enable is low must not land
        @(posedge core_clk);
        en <= 1'b0;
        host.write_reg(mspc_pkg::ADDR_DIVIDER, 8'h5a);
        en <= 1'b1;
        host.read_reg(mspc_pkg::ADDR_DIVIDER, rd_val);
        check("clk_en_in freeze", {8'h00, rd_val}, {8'h00, mspc_pkg::RST_DIVIDER});
        // Divider is ignored under bypass, so every strobe is an output strobe
        host.write_reg(mspc_pkg::ADDR_DIVIDER, 8'h03);
        wait_strobe();
        wait_strobe();
        check("strobe period", 16'(gap), 16'(mspc_pkg::DIV_32K));
        for (int n = 0; n < 8; n++) begin
            logic [7:0] mask;
            host.write_reg(mspc_pkg::ADDR_SYNC_FILTER, {2'b00, 3'(n), 3'b000});
            mask = (n == 0) ? 8'h00 : (8'h01 << (n - 1));
            if (n != 0) begin
                // Short pulse: two toggles, only the first may flip the latch
                @(posedge core_clk);
                fs <= 1'b1;
                repeat (2) @(posedge core_clk);
                fs <= 1'b0;
                lat = ~lat;
            end
            wait_strobe();
            check("slot_lsb_out", {8'h00, slot_out},
                {8'h00, (8'haa & ~mask) | (lat ? mask : 8'h00)});
            check("output_strobe_out", {15'h0000, o_stb}, 16'h0001);
        end
        fifo_run(1'b1, 0);
        fifo_run(1'b0, 2);
        end_of_test();
    end
endmodule // testbench
